// ==== src/hhad_decoder.sv ====
// Contract
// - Anything above 2 KB RAM in first 16 MB aliases on low eleven bits.
// - Reads in unused regions, and from 0E000000 upward, raise data abort.
// - Banked flash reads in disabled bank or beyond 128 KB abort.
// - 16 KB boot ROM repeats over its 16 MB region, fourteen bits.
// - 128 KB linear flash repeats over its 16 MB region, seventeen bits.
// - Flash-control holes read zero: after waits, after bank table, above extra.
// - Interrupt region past acknowledge port reads the enable word.
// - Timer fourth words and everything past third block read timer zero reload.
// - Calendar addresses above date word read time-of-day word.
// - Unused communication word between data and control reads zero.
// - Display holes around pixel memory read zero.
// - Byte reads of ROM or flash return garbage byte from prefetch and RAM word.
// - Remembered RAM word updates only on RAM data reads.
// - Odd byte reads in timer region act as read at first odd address.
// - Halfword calendar read with A1 set returns date word upper half.
// - RAM takes byte, halfword and word reads and writes freely.
// - After reset boot ROM sits at address zero instead of RAM.
// - Banked flash translates in 2000h banks, each onto one flash block.
// - Row mask: 0 all rows, 1-4 quarters, 5-7 first, middle, bottom halves.
// - Fade bit: clear fades panel out, set runs normally.
// - Refresh field: 1 about 64 Hz, 2 32 Hz, 3 16 Hz; 0 avoided.
// - Display-on bit: 0 panel off, 1 panel on.
// - Bit 7 rotates image 180 degrees; bits 8-31 unused, read zero.
`timescale 1ns/1ps
module hhad_decoder (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [31:0]            s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [31:0]            s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   cpu_req,
    input  wire logic                   cpu_we,
    input  wire logic                   cpu_fetch,
    input  wire hhad_pkg::hhad_size_e   cpu_size,
    input  wire logic [31:0]            cpu_addr,
    input  wire logic [31:0]            cpu_wdata,
    input  wire logic [31:0]            cpu_prefetch,
    output logic                        cpu_ack,
    output logic [31:0]                 cpu_rdata,
    output logic                        cpu_abort,
    output logic [hhad_pkg::ROM_AW-1:0] rom_addr,
    input  wire logic [31:0]            rom_rdata,
    output logic [hhad_pkg::FL_AW-1:0]  flash_addr,
    input  wire logic [31:0]            flash_rdata,
    input  wire logic [15:0]            bank_enable,
    input  wire logic [63:0]            bank_block,
    output logic [31:0]                 io_addr,
    output logic                        io_we,
    output logic                        io_re,
    output logic [31:0]                 io_wdata,
    input  wire logic [31:0]            io_rdata,
    input  wire logic [31:0]            int_enable_word,
    input  wire logic [31:0]            timer_zero_reload_value,
    input  wire logic [31:0]            rtc_time_word,
    input  wire logic [31:0]            rtc_date_word,
    output logic [31:0]                 row_enable,
    output logic                        panel_fade_control,
    output logic [1:0]                  refresh_sel,
    output logic                        display_on,
    output logic                        rotate_180
);
    import hhad_pkg::*;

    hhad_tgt_e   tgt;
    logic [7:0]  top;
    logic [23:0] off;
    logic        is_rd, garb, lane1, do_wr;
    logic [3:0]  be, bidx, ws_r;
    logic [31:0] ram_word, word, shw, rd_nxt, garb_word;
    logic [31:0] ram_last_r;
    logic [31:0] cpu_rdata_r;
    logic        cpu_abort_r, cpu_ack_r, map_r;
    logic [7:0]  disp_r;
    logic [15:0] abort_cnt_r;
    logic [31:0] pix_mem [PIX_WDS];
    logic        aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [31:0] wa_r, wd_r, axi_rd_r;
    logic [1:0]  bresp_r, rresp_r;

    assign top   = cpu_addr[31:24];
    assign off   = cpu_addr[23:0];
    assign is_rd = cpu_req && !cpu_we;
    assign bidx  = off[BANK_AW+BLK_W-1:BANK_AW];

    // Region and sub-region decode
    always_comb begin
        tgt = T_ABORT;
        case (top)
            RG_RAM: tgt = map_r ? T_RAM : T_ROM;
            RG_VFL: tgt = (off < VFL_SIZE && bank_enable[bidx]) ? T_FLASH : T_ABORT;
            RG_ROM: tgt = T_ROM;
            RG_LFL: tgt = T_FLASH;
            RG_FCT: tgt = (off < FCT_GAP0 || (off >= FCT_BVAL && off < FCT_BEND) ||
                          (off >= FCT_XTRA && off < FCT_XEND)) ? T_IO : T_ZERO;
            RG_INT: begin
                if (off[23]) begin
                    if (off >= TMR_END || off[3:0] == TMR_W3 || (cpu_size == SZ_BYTE && off[0])) begin
                        tgt = T_T0R;
                    end else begin
                        tgt = T_IO;
                    end
                end else begin
                    tgt = (off >= INT_MIRR) ? T_INTEN : T_IO;
                end
            end
            RG_CLK: begin
                if (off[23] && !cpu_we && cpu_size == SZ_HALF && off[1]) begin
                    tgt = T_RDATE;
                end else if (!off[23] || off < RTC_TIME) begin
                    tgt = T_IO;
                end else if (off >= RTC_DATE && off < RTC_MIRR) begin
                    tgt = T_RDATE;
                end else begin
                    tgt = T_RTIME;
                end
            end
            RG_COM: tgt = (!off[23] && (off >= COM_GAP || off[23:2] == COM_ZERO[23:2])) ?
                          T_ZERO : T_IO;
            RG_LCD: begin
                if (off[23]) begin
                    tgt = T_IO;
                end else if (off < LCD_DEND) begin
                    tgt = T_DISP;
                end else if (off < LCD_CEND) begin
                    tgt = T_IO;
                end else if (off >= PIX_BASE && off < PIX_END) begin
                    tgt = T_PIX;
                end else begin
                    tgt = T_ZERO;
                end
            end
            default: tgt = T_ABORT;
        endcase
    end

    assign lane1 = top == RG_INT && off[23] && cpu_size == SZ_BYTE && off[0];
    assign garb  = cpu_size == SZ_BYTE && (tgt == T_ROM || tgt == T_FLASH ||
                   (top == RG_FCT && off >= FCT_XTRA && off < FCT_XEND));
    assign garb_word = cpu_prefetch | (ram_last_r & GARB_MSK);

    assign rom_addr   = cpu_addr[ROM_AW-1:0];
    // Banked window keeps the in-bank offset and swaps the bank for a block
    assign flash_addr = (top == RG_VFL) ?
        {bank_block[BLK_W*bidx +: BLK_W], off[BANK_AW-1:0]} : off[FL_AW-1:0];
    assign io_addr    = cpu_addr;
    assign io_wdata   = cpu_wdata;
    assign io_we      = cpu_req && cpu_we && tgt == T_IO;
    assign io_re      = is_rd && tgt == T_IO;

    always_comb begin
        case (cpu_size)
            SZ_BYTE: be = 4'h1 << cpu_addr[1:0];
            SZ_HALF: be = cpu_addr[1] ? 4'hC : 4'h3;
            default: be = 4'hF;
        endcase
    end

    // RAM in four byte lanes so any access width writes only its lanes
    for (genvar i = 0; i < 4; i++) begin : g_lane
        logic [7:0] mem [RAM_WDS];
        always_ff @(posedge aclk) begin
            if (cpu_req && cpu_we && tgt == T_RAM && be[i]) begin
                mem[cpu_addr[RAM_AW-1:2]] <= cpu_wdata[8*i +: 8];
            end
        end
        assign ram_word[8*i +: 8] = mem[cpu_addr[RAM_AW-1:2]];
    end

    always_ff @(posedge aclk) begin
        if (cpu_req && cpu_we && tgt == T_PIX) begin
            pix_mem[off[6:2]] <= cpu_wdata;
        end
    end

    always_comb begin
        case (tgt)
            T_RAM:   word = ram_word;
            T_ROM:   word = rom_rdata;
            T_FLASH: word = flash_rdata;
            T_PIX:   word = pix_mem[off[6:2]];
            T_DISP:  word = {24'h000000, disp_r};
            T_T0R:   word = timer_zero_reload_value;
            T_RTIME: word = rtc_time_word;
            T_RDATE: word = rtc_date_word;
            T_INTEN: word = int_enable_word;
            T_IO:    word = io_rdata;
            default: word = 32'h00000000;
        endcase
        if (garb) begin
            word = garb_word;
        end
        shw = 32'h00000000;
        case (cpu_size)
            SZ_BYTE: begin
                shw    = word >> {(lane1 ? 2'b01 : cpu_addr[1:0]), 3'b000};
                rd_nxt = {24'h000000, shw[7:0]};
            end
            SZ_HALF: begin
                shw    = word >> {cpu_addr[1], 4'h0};
                rd_nxt = {16'h0000, shw[15:0]};
            end
            default: rd_nxt = word;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_ack_r   <= 1'b0;
            cpu_abort_r <= 1'b0;
            cpu_rdata_r <= 32'h00000000;
        end else begin
            cpu_ack_r   <= cpu_req;
            cpu_abort_r <= is_rd && tgt == T_ABORT;
            if (is_rd) begin
                cpu_rdata_r <= (tgt == T_ABORT) ? 32'h00000000 : rd_nxt;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ram_last_r <= 32'h00000000;
        end else if (is_rd && !cpu_fetch && tgt == T_RAM) begin
            ram_last_r <= ram_word;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            abort_cnt_r <= 16'h0000;
        end else if (is_rd && tgt == T_ABORT) begin
            abort_cnt_r <= abort_cnt_r + 16'h0001;
        end
    end

    assign cpu_ack   = cpu_ack_r;
    assign cpu_abort = cpu_abort_r;
    assign cpu_rdata = cpu_rdata_r;

    // AXI4-Lite slave
    assign do_wr         = aw_got_r && w_got_r && !bvalid_r;
    assign s_axi_awready = !aw_got_r;
    assign s_axi_wready  = !w_got_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = axi_rd_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= R_OKAY;
            wa_r     <= 32'h00000000;
            wd_r     <= 32'h00000000;
            ws_r     <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_got_r) begin
                aw_got_r <= 1'b1;
                wa_r     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got_r) begin
                w_got_r <= 1'b1;
                wd_r    <= s_axi_wdata;
                ws_r    <= s_axi_wstrb;
            end
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r  <= (wa_r[31:2] == A_DISP[31:2] || wa_r[31:2] == A_MAP[31:2] ||
                             wa_r[31:2] == A_STAT[31:2]) ? R_OKAY : R_DECERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            axi_rd_r <= 32'h00000000;
            rresp_r  <= R_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= R_OKAY;
            if (s_axi_araddr[31:2] == A_DISP[31:2]) begin
                axi_rd_r <= {24'h000000, disp_r};
            end else if (s_axi_araddr[31:2] == A_MAP[31:2]) begin
                axi_rd_r <= {31'h00000000, map_r};
            end else if (s_axi_araddr[31:2] == A_STAT[31:2]) begin
                axi_rd_r <= {16'h0000, abort_cnt_r};
            end else begin
                axi_rd_r <= 32'h00000000;
                rresp_r  <= R_DECERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Display word: bus write wins over a same-cycle processor write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disp_r <= DW_RST;
        end else if (do_wr && wa_r[31:2] == A_DISP[31:2]) begin
            if (ws_r[0]) begin
                disp_r <= wd_r[7:0];
            end
        end else if (cpu_req && cpu_we && tgt == T_DISP && be[0]) begin
            disp_r <= cpu_wdata[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            map_r <= 1'b0;
        end else if (do_wr && wa_r[31:2] == A_MAP[31:2] && ws_r[0]) begin
            map_r <= wd_r[0];
        end
    end

    always_comb begin
        case (disp_r[2:0])
            3'h1:    row_enable = 32'h000000FF;
            3'h2:    row_enable = 32'h0000FF00;
            3'h3:    row_enable = 32'h00FF0000;
            3'h4:    row_enable = 32'hFF000000;
            3'h5:    row_enable = 32'h0000FFFF;
            3'h6:    row_enable = 32'h00FFFF00;
            3'h7:    row_enable = 32'hFFFF0000;
            default: row_enable = 32'hFFFFFFFF;
        endcase
    end

    assign panel_fade_control = disp_r[DW_FADE];
    assign refresh_sel        = disp_r[DW_RATE +: 2];
    assign display_on         = disp_r[DW_ON];
    assign rotate_180         = disp_r[DW_ROT];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_UNUSED_ABORT: assert property (is_rd && (top >= 8'h0E || top == 8'h01 ||
        top == 8'h05) |=> cpu_abort && cpu_rdata == 32'h00000000)
        else $error("unused read no abort");
    AST_VFL_RANGE: assert property (is_rd && top == RG_VFL && off >= VFL_SIZE
        |=> cpu_abort) else $error("banked flash overrun no abort");
    AST_VFL_BANK: assert property (is_rd && top == RG_VFL && !bank_enable[bidx]
        |=> cpu_abort) else $error("disabled bank no abort");
    AST_RAMLAST_HOLD: assert property (cpu_req && (cpu_we || top != RG_RAM)
        |=> $stable(ram_last_r)) else $error("remembered word moved");
    AST_COM_ZERO: assert property (is_rd && top == RG_COM && off == COM_ZERO
        |=> cpu_rdata == 32'h00000000 && !cpu_abort) else $error("com gap not zero");
    AST_T0R_MIRROR: assert property (is_rd && cpu_size == SZ_WORD && top == RG_INT &&
        off == TMR_END |=> cpu_rdata == $past(timer_zero_reload_value))
        else $error("timer mirror wrong");
    AST_INTEN: assert property (is_rd && cpu_size == SZ_WORD && top == RG_INT &&
        off == INT_MIRR |=> cpu_rdata == $past(int_enable_word)) else $error("int mirror wrong");
    AST_RTC_HALF: assert property (is_rd && cpu_size == SZ_HALF && top == RG_CLK &&
        off[23] && off[1] |=> cpu_rdata == ($past(rtc_date_word) >> 16))
        else $error("date half wrong");
    AST_BOOT_ROM: assert property ($rose(aresetn) |-> !map_r [*4])
        else $error("ram at zero after reset");
    AST_ROW_ALL: assert property (disp_r[2:0] == 3'h0 |-> row_enable == 32'hFFFFFFFF)
        else $error("row mask zero wrong");
    AST_ACK: assert property (cpu_req |=> cpu_ack ##1 (cpu_ack == $past(cpu_req)))
        else $error("ack missing");
    COV_GARB: cover property (is_rd && garb ##1 cpu_ack);
    COV_ABORT: cover property (is_rd && tgt == T_ABORT ##1 cpu_abort);
    COV_AXI_WR: cover property (do_wr ##[1:4] (bvalid_r && s_axi_bready));
    COV_RAM_MAP: cover property ($rose(map_r) ##1 is_rd && tgt == T_RAM);
endmodule

// ==== src/hhad_pkg.sv ====
package hhad_pkg;
    // Region selector: top address byte, 16 MB steps
    localparam logic [7:0]  RG_RAM   = 8'h00;
    localparam logic [7:0]  RG_VFL   = 8'h02;
    localparam logic [7:0]  RG_ROM   = 8'h04;
    localparam logic [7:0]  RG_FCT   = 8'h06;
    localparam logic [7:0]  RG_LFL   = 8'h08;
    localparam logic [7:0]  RG_INT   = 8'h0A;
    localparam logic [7:0]  RG_CLK   = 8'h0B;
    localparam logic [7:0]  RG_COM   = 8'h0C;
    localparam logic [7:0]  RG_LCD   = 8'h0D;
    // Offsets inside a 16 MB region
    localparam logic [23:0] FCT_GAP0 = 24'h000014;
    localparam logic [23:0] FCT_BVAL = 24'h000100;
    localparam logic [23:0] FCT_BEND = 24'h000140;
    localparam logic [23:0] FCT_XTRA = 24'h000300;
    localparam logic [23:0] FCT_XEND = 24'h000400;
    localparam logic [23:0] INT_MIRR = 24'h000014;
    localparam logic [23:0] TMR_END  = 24'h800030;
    localparam logic [3:0]  TMR_W3   = 4'hC;
    localparam logic [23:0] RTC_TIME = 24'h800008;
    localparam logic [23:0] RTC_DATE = 24'h80000C;
    localparam logic [23:0] RTC_MIRR = 24'h800010;
    localparam logic [23:0] COM_ZERO = 24'h00000C;
    localparam logic [23:0] COM_GAP  = 24'h00001C;
    localparam logic [23:0] LCD_CEND = 24'h000008;
    localparam logic [23:0] LCD_DEND = 24'h000004;
    localparam logic [23:0] PIX_BASE = 24'h000100;
    localparam logic [23:0] PIX_END  = 24'h000180;
    localparam logic [23:0] VFL_SIZE = 24'h020000;
    localparam int          RAM_AW   = 11;
    localparam int          ROM_AW   = 14;
    localparam int          FL_AW    = 17;
    localparam int          BANK_AW  = 13;
    localparam int          BLK_W    = 4;
    localparam int          RAM_WDS  = 512;
    localparam int          PIX_WDS  = 32;
    localparam logic [31:0] GARB_MSK = 32'hFFFFFFD0;
    // AXI register map
    localparam logic [31:0] A_DISP   = 32'h0D000000;
    localparam logic [31:0] A_MAP    = 32'h0D0000F0;
    localparam logic [31:0] A_STAT   = 32'h0D0000F4;
    localparam logic [1:0]  R_OKAY   = 2'b00;
    localparam logic [1:0]  R_DECERR = 2'b11;
    // Display control word fields
    localparam int          DW_FADE  = 3;
    localparam int          DW_RATE  = 4;
    localparam int          DW_ON    = 6;
    localparam int          DW_ROT   = 7;
    localparam logic [7:0]  DW_RST   = 8'h00;
    typedef enum logic [1:0] {SZ_BYTE = 2'b00, SZ_HALF = 2'b01, SZ_WORD = 2'b10} hhad_size_e;
    typedef enum logic [3:0] {
        T_RAM = 4'b0000, T_ROM = 4'b0001, T_FLASH = 4'b0010, T_PIX = 4'b0011,
        T_DISP = 4'b0100, T_ZERO = 4'b0101, T_T0R = 4'b0110, T_RTIME = 4'b0111,
        T_RDATE = 4'b1000, T_INTEN = 4'b1001, T_IO = 4'b1010, T_ABORT = 4'b1011
    } hhad_tgt_e;
endpackage

// ==== tb/hhad_cpu_model.sv ====
`timescale 1ns/1ps
module hhad_cpu_model #(
    parameter logic [31:0] PF = 32'h12345678
) (
    input  wire logic         aclk,
    output logic              cpu_req,
    output logic              cpu_we,
    output logic              cpu_fetch,
    output hhad_pkg::hhad_size_e cpu_size,
    output logic [31:0]       cpu_addr,
    output logic [31:0]       cpu_wdata,
    output logic [31:0]       cpu_prefetch,
    input  wire logic         cpu_ack,
    input  wire logic [31:0]  cpu_rdata,
    input  wire logic         cpu_abort
);
    import hhad_pkg::*;
    assign cpu_prefetch = PF;
    initial begin
        {cpu_req, cpu_we, cpu_fetch, cpu_addr, cpu_wdata} = '0;
        cpu_size = SZ_WORD;
    end
    // One request cycle, then the answer is taken while ack stands
    task automatic acc(input logic w, input hhad_size_e s, input logic [31:0] a, d,
                       output logic [31:0] q, output logic ab, k);
        {cpu_we, cpu_addr, cpu_wdata, cpu_req} <= {w, a, d, 1'b1};
        cpu_size <= s;
        @(posedge aclk);
        cpu_req <= 1'b0;
        cpu_addr <= ~a;
        @(posedge aclk);
        {q, ab, k} = {cpu_rdata, cpu_abort, cpu_ack};
    endtask
endmodule

// ==== tb/test_handheld_address_decoder.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_handheld_address_decoder;
    import hhad_pkg::*;
    localparam logic [31:0] PF = 32'h12345678;
    localparam logic [31:0] ROWS [8] = '{32'hFFFFFFFF, 32'h000000FF, 32'h0000FF00,
        32'h00FF0000, 32'hFF000000, 32'h0000FFFF, 32'h00FFFF00, 32'hFFFF0000};
    logic        aclk, aresetn, cpu_req, cpu_we, cpu_fetch, cpu_ack, cpu_abort, ab, k;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        panel_fade_control, display_on, rotate_180, io_we, io_re;
    logic [1:0]  s_axi_bresp, s_axi_rresp, refresh_sel, rp;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, cpu_addr, cpu_wdata;
    logic [31:0] cpu_prefetch, cpu_rdata, io_addr, io_wdata, io_rdata, row_enable, q;
    logic [31:0] int_enable_word, timer_zero_reload_value, rtc_time_word, rtc_date_word;
    logic [31:0] rom_rdata, flash_rdata;
    logic [13:0] rom_addr;
    logic [16:0] flash_addr;
    logic [15:0] bank_enable;
    logic [63:0] bank_block;
    hhad_size_e  cpu_size;
    int          num_errors, checks, cyc, m;
    hhad_decoder DUT (.*);
    hhad_cpu_model #(.PF(PF)) cpu (.*);
    assign rom_rdata = {18'h1, rom_addr};
    assign flash_rdata = {15'h0, flash_addr};
    assign io_rdata = ~io_addr;
    assign int_enable_word = cpu_addr ^ 32'h11111111;
    assign timer_zero_reload_value = cpu_addr ^ 32'h22222222;
    assign rtc_time_word = cpu_addr ^ 32'h33333333;
    assign rtc_date_word = cpu_addr ^ 32'h44444444;
    function automatic logic [7:0] gb(input int o);
        gb = 8'((PF | (32'hCAFE5A0D & GARB_MSK)) >> (8 * o));
    endfunction
    task automatic finish_test;
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Expectation is {abort, data}; data is not judged on an abort
    task automatic rd(input logic [31:0] a, input hhad_size_e s, input logic [32:0] e);
        cpu.acc(1'b0, s, a, 32'h0, q, ab, k);
        `CHK({k, ab, e[32] ? e[31:0] : q}, {1'b1, e})
    endtask
    initial begin
        aclk = 0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awprot, s_axi_arprot, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_wstrb, bank_enable, bank_block} = {4'hF, 16'h0001, 64'h5};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(32'h0, SZ_WORD, {1'b0, 32'h00004000});
        axw(A_MAP, 32'h1, rp);
        cpu.acc(1'b1, SZ_WORD, 32'h10, 32'hCAFEF00D, q, ab, k);
        cpu.acc(1'b1, SZ_BYTE, 32'h11, 32'h00005A00, q, ab, k);
        rd(32'h00800010, SZ_WORD, {1'b0, 32'hCAFE5A0D});
        rd(32'h00000012, SZ_HALF, {1'b0, 32'h0000CAFE});
        cpu.acc(1'b1, SZ_WORD, 32'h20, 32'h0, q, ab, k);
        rd(32'h04000001, SZ_BYTE, {25'h0, gb(1)});
        rd(32'h08000002, SZ_BYTE, {25'h0, gb(2)});
        rd(32'h02000004, SZ_WORD, {1'b0, 32'h0000A004});
        rd(32'h02002000, SZ_WORD, {1'b1, 32'h0});
        rd(32'h02020000, SZ_WORD, {1'b1, 32'h0});
        rd(32'h04004010, SZ_WORD, {1'b0, 32'h00004010});
        rd(32'h08020008, SZ_WORD, {1'b0, 32'h00000008});
        foreach (ROWS[i]) rd({i[2:0] + 3'd1, 28'h0} | 32'h0E000000, SZ_WORD, 33'h1_00000000);
        rd(32'h05000000, SZ_WORD, {1'b1, 32'h0});
        rd(32'h06000014, SZ_WORD, 33'h0);
        rd(32'h06000140, SZ_WORD, 33'h0);
        rd(32'h06000400, SZ_WORD, 33'h0);
        rd(32'h0C00000C, SZ_WORD, 33'h0);
        rd(32'h0D000008, SZ_WORD, 33'h0);
        rd(32'h0D000180, SZ_WORD, 33'h0);
        rd(32'h0A000014, SZ_WORD, {1'b0, 32'h0A000014 ^ 32'h11111111});
        rd(32'h0A80001C, SZ_WORD, {1'b0, 32'h0A80001C ^ 32'h22222222});
        rd(32'h0A800030, SZ_WORD, {1'b0, 32'h0A800030 ^ 32'h22222222});
        rd(32'h0A800003, SZ_BYTE, {25'h0, 8'h22 ^ 8'h00});
        rd(32'h0B800010, SZ_WORD, {1'b0, 32'h0B800010 ^ 32'h33333333});
        rd(32'h0B800002, SZ_HALF, {17'h0, 16'h0B80 ^ 16'h4444});
        for (m = 0; m < 8; m++) begin
            axw(A_DISP, 32'h58 | m, rp);
            `CHK({row_enable, panel_fade_control, refresh_sel, display_on}, {ROWS[m], 4'hB})
        end
        axw(A_DISP, 32'hFFFFFFA2, rp);
        `CHK({panel_fade_control, refresh_sel, display_on, rotate_180}, 5'b01001)
        axr(A_DISP, q, rp);
        `CHK({rp, q}, {R_OKAY, 32'h000000A2})
        axw(A_DISP, 32'h30, rp);
        `CHK({refresh_sel, row_enable}, {2'b11, ROWS[0]})
        axw(32'h0D0000F8, 32'h1, rp);
        `CHK(rp, R_DECERR)
        rd(32'h0C000008, SZ_WORD, {1'b0, ~32'h0C000008});
        axr(A_STAT, q, rp);
        `CHK({rp, q}, {R_OKAY, 32'h0000000B})
        finish_test();
    end
endmodule
